//--- logic/pas_supervisor.sv
// precharge contactor sequence supervisor with AHB-Lite registers
//
// Notes on behaviour
// - sequence stages not done in 30 s: timeout exit, stage recorded
// - first charge close unacked in 1 s: exit, precharge fault, alarm
// - bypass open unacked in 1 s: exit, fault, contactor, breaker alarm
// - second charge no close ack in 1 s or voltage drop: exit, alarm
// - first charge open unacked in 1 s: exit, fault, both alarms
// - second charge open unacked 1 s: exit, still closed, both alarms
// - medium voltage lost awaiting fault reset: wait-reset exit, fault
// - main input inhibited outside service mode: main-user-open exit
// - disable flag or low cell bus before main close: main-user-open
// - enable dropped awaiting main close: enable-lost exit and fault
// - low cell bus awaiting main close: low-dc exit, main fault
// - voltage under 80% awaiting main close: no-voltage exit, main fault
// - clean completion, service mode too: success exit, no fault
`timescale 1ns/10ps
`include "pas_params.svh"
module pas_supervisor
  import pas_pkg::*;
#(
  parameter logic [31:0] TICK_CYCLES = 32'(`PAS_TICK_CYCLES)
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        precharge_enable_flag,
  input  wire logic        main_input_disable_flag,
  input  wire logic        mv_built_up,
  input  wire logic        medium_voltage_level_ok,
  input  wire logic        cell_low_dc_bus,
  input  wire logic        cell_diag_done,
  input  wire logic        fault_reset_done,
  input  wire logic        in_sync_relay,
  input  wire logic        first_charge_closed_ack,
  input  wire logic        bypass_open_ack,
  input  wire logic        second_charge_closed_ack,
  input  wire logic        main_input_closed_ack,
  output logic             first_charge_close_cmd,
  output logic             bypass_open_cmd,
  output logic             second_charge_close_cmd,
  output logic             main_input_close_cmd,
  output logic             precharge_fault,
  output logic             main_contactor_fault,
  output logic             contactor_alarm,
  output logic             breaker_opened_alarm,
  output logic             contactor_still_closed,
  output logic             event_pulse,
  output logic             irq
);

  typedef struct packed {
    pas_fsm_t  state;
    pas_exit_t exit_code;
    logic [3:0] stage;
    logic      pfault;
    logic      mfault;
    logic      calarm;
    logic      balarm;
    logic      still;
    logic      event_p;
    logic      service;
    logic [31:0] prescale;
    logic [`PAS_IRQ_BITS-1:0] int_stat;
    logic [`PAS_IRQ_BITS-1:0] int_mask;
    logic      a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } pas_state_t;

  pas_state_t cur_ff;
  pas_state_t nxt_cur;
  pas_time_if tmr ();

  // ends the attempt with one code and its fault and alarm indications
  function automatic pas_state_t finish(input pas_state_t s,
                                        input pas_exit_t  code,
                                        input logic       pf,
                                        input logic       mf,
                                        input logic       ca,
                                        input logic       ba,
                                        input logic       sc);
    pas_state_t r;
    r           = s;
    r.state     = PAS_DONE;
    r.exit_code = code;
    r.pfault    = pf;
    r.mfault    = mf;
    r.calarm    = ca;
    r.balarm    = ba;
    r.still     = sc;
    r.event_p   = 1'b1;
    return r;
  endfunction : finish

  // stage index reported with a sequence timeout
  function automatic logic [3:0] stage_of(input pas_fsm_t st);
    case (st)
      PAS_VOLTS: stage_of = 4'h1;
      PAS_C1CLS: stage_of = 4'h2;
      PAS_BYOPN: stage_of = 4'h3;
      PAS_C2CLS: stage_of = 4'h4;
      PAS_C1OPN: stage_of = 4'h5;
      default:   stage_of = 4'h0;
    endcase
  endfunction : stage_of

  logic       inhibit;
  logic       a_valid;
  logic       in_seq;
  logic [`PAS_IRQ_BITS-1:0] ev_bits;
  logic [`PAS_IRQ_BITS-1:0] clr_bits;

  // sequencer, register file and bus slave in one next-state process
  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.event_p = 1'b0;
    inhibit = main_input_disable_flag && !cur_ff.service;
    in_seq  = 1'b0;
    case (cur_ff.state)
      PAS_IDLE: begin
        // a new attempt clears the previous outcome
        if (precharge_enable_flag) begin
          nxt_cur           = finish(cur_ff, PAS_EX_NONE,
                                     1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
          nxt_cur.event_p   = 1'b0;
          nxt_cur.stage     = 4'h0;
          nxt_cur.state     = PAS_VOLTS;
        end
      end
      PAS_VOLTS, PAS_C1CLS, PAS_BYOPN, PAS_C2CLS, PAS_C1OPN: begin
        in_seq = 1'b1;
        if (!precharge_enable_flag) begin
          nxt_cur = finish(cur_ff, PAS_EX_USER_ABORT,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (cur_ff.state == PAS_VOLTS && inhibit) begin
          nxt_cur = finish(cur_ff, PAS_EX_MAIN_USER,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (tmr.long_expired) begin
          nxt_cur = finish(cur_ff, PAS_EX_TIMEOUT,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
          nxt_cur.stage = stage_of(cur_ff.state);
        end else begin
          case (cur_ff.state)
            PAS_VOLTS: begin
              if (mv_built_up) nxt_cur.state = PAS_C1CLS;
            end
            PAS_C1CLS: begin
              if (first_charge_closed_ack) begin
                nxt_cur.state = PAS_BYOPN;
              end else if (tmr.short_expired) begin
                nxt_cur = finish(cur_ff, PAS_EX_C1_CLOSE,
                                 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
              end
            end
            PAS_BYOPN: begin
              if (bypass_open_ack) begin
                nxt_cur.state = PAS_C2CLS;
              end else if (tmr.short_expired) begin
                nxt_cur = finish(cur_ff, PAS_EX_BYP_OPEN,
                                 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
              end
            end
            PAS_C2CLS: begin
              if (second_charge_closed_ack) begin
                nxt_cur.state = PAS_C1OPN;
              end else if (tmr.short_expired) begin
                nxt_cur = finish(cur_ff, PAS_EX_C2_CLOSE,
                                 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
              end
            end
            default: begin
              // voltage must hold once the second charge path is acked
              if (!mv_built_up) begin
                nxt_cur = finish(cur_ff, PAS_EX_C2_CLOSE,
                                 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
              end else if (!first_charge_closed_ack) begin
                nxt_cur.state = PAS_RSTW;
              end else if (tmr.short_expired) begin
                nxt_cur = finish(cur_ff, PAS_EX_C1_OPEN,
                                 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
              end
            end
          endcase
        end
      end
      PAS_RSTW, PAS_DIAG, PAS_SYNC: begin
        if (!precharge_enable_flag) begin
          nxt_cur = finish(cur_ff, PAS_EX_USER_ABORT,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (inhibit) begin
          nxt_cur = finish(cur_ff, PAS_EX_MAIN_USER,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (cur_ff.state == PAS_RSTW) begin
          if (!mv_built_up) begin
            nxt_cur = finish(cur_ff, PAS_EX_WAIT_RESET,
                             1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
          end else if (fault_reset_done) begin
            nxt_cur.state = PAS_DIAG;
          end
        end else if (cell_low_dc_bus) begin
          nxt_cur = finish(cur_ff, PAS_EX_MAIN_USER,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (cur_ff.state == PAS_DIAG) begin
          if (cell_diag_done) nxt_cur.state = PAS_SYNC;
        end else if (in_sync_relay) begin
          nxt_cur.state = PAS_MAIN;
        end
      end
      PAS_MAIN: begin
        // enable loss outranks the measurement faults
        if (!precharge_enable_flag) begin
          nxt_cur = finish(cur_ff, PAS_EX_ENA_LOST_MC,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (main_input_disable_flag) begin
          nxt_cur = finish(cur_ff, PAS_EX_MAIN_USER,
                           1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (cell_low_dc_bus) begin
          nxt_cur = finish(cur_ff, PAS_EX_LOW_DC_MC,
                           1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        end else if (!medium_voltage_level_ok) begin
          nxt_cur = finish(cur_ff, PAS_EX_NO_VOLT_MC,
                           1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        end else if (main_input_closed_ack) begin
          nxt_cur.state = PAS_C2OPN;
        end
      end
      PAS_C2OPN: begin
        if (!second_charge_closed_ack) begin
          nxt_cur = finish(cur_ff, PAS_EX_SUCCESS,
                           1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (tmr.short_expired) begin
          nxt_cur = finish(cur_ff, PAS_EX_C2_OPEN,
                           1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        end
      end
      PAS_DONE: begin
        // outcome holds until the enable is withdrawn
        if (!precharge_enable_flag) nxt_cur.state = PAS_IDLE;
      end
      default: begin
        nxt_cur.state = PAS_IDLE;
      end
    endcase

    // status events; a set in the clearing cycle wins
    ev_bits = {nxt_cur.balarm, nxt_cur.calarm, nxt_cur.mfault,
               nxt_cur.pfault, 1'b1} & {`PAS_IRQ_BITS{nxt_cur.event_p}};
    clr_bits = '0;

    // data phase write of the previous address phase
    if (cur_ff.a_wr) begin
      case (cur_ff.a_addr)
        `PAS_OFS_CTRL:     nxt_cur.service = hwdata[`PAS_CTRL_SERVICE];
        `PAS_OFS_PRESCALE: nxt_cur.prescale = hwdata;
        `PAS_OFS_INT_STAT: clr_bits = hwdata[`PAS_IRQ_BITS-1:0];
        `PAS_OFS_INT_MASK: nxt_cur.int_mask = hwdata[`PAS_IRQ_BITS-1:0];
        default: ;
      endcase
    end
    nxt_cur.int_stat = (cur_ff.int_stat & ~clr_bits) | ev_bits;

    // address phase: only whole-word transfers are decoded
    a_valid = hsel && htrans[1] && hready && (hsize == 3'h2);
    nxt_cur.a_wr   = a_valid && hwrite;
    nxt_cur.a_addr = haddr[7:0];
    nxt_cur.rdata  = 32'h0;
    if (a_valid && !hwrite) begin
      case (haddr[7:0])
        `PAS_OFS_CTRL:     nxt_cur.rdata[`PAS_CTRL_SERVICE] = cur_ff.service;
        `PAS_OFS_PRESCALE: nxt_cur.rdata = cur_ff.prescale;
        `PAS_OFS_STATUS: begin
          nxt_cur.rdata[`PAS_ST_EXIT_LSB +: 4]   = cur_ff.exit_code;
          nxt_cur.rdata[`PAS_ST_STAGE_LSB +: 4]  = cur_ff.stage;
          nxt_cur.rdata[`PAS_ST_BUSY] =
            (cur_ff.state != PAS_IDLE) && (cur_ff.state != PAS_DONE);
          nxt_cur.rdata[`PAS_ST_STATE_LSB +: 12] = cur_ff.state;
        end
        `PAS_OFS_INT_STAT: nxt_cur.rdata[`PAS_IRQ_BITS-1:0] = cur_ff.int_stat;
        `PAS_OFS_INT_MASK: nxt_cur.rdata[`PAS_IRQ_BITS-1:0] = cur_ff.int_mask;
        default: ;
      endcase
    end
  end

  // timer requests: restart the ack timer on every command change
  assign tmr.short_restart = (nxt_cur.state != cur_ff.state);
  assign tmr.long_restart  = (cur_ff.state == PAS_IDLE);
  assign tmr.long_run      = in_seq;

  pas_timebase u_timebase (
    .clock       (clock),
    .reset       (reset),
    .tick_cycles (cur_ff.prescale),
    .tm          (tmr)
  );

  // single state register; resets to constants only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_ff           <= '0;
      cur_ff.state     <= PAS_IDLE;
      cur_ff.exit_code <= PAS_EX_NONE;
      cur_ff.service   <= `PAS_CTRL_RESET;
      cur_ff.prescale  <= TICK_CYCLES;
      cur_ff.int_mask  <= `PAS_MASK_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // contactor commands follow the registered stage
  always_comb begin
    first_charge_close_cmd  = 1'b0;
    bypass_open_cmd         = 1'b0;
    second_charge_close_cmd = 1'b0;
    main_input_close_cmd    = 1'b0;
    case (cur_ff.state)
      PAS_C1CLS: first_charge_close_cmd = 1'b1;
      PAS_BYOPN: begin
        first_charge_close_cmd = 1'b1;
        bypass_open_cmd        = 1'b1;
      end
      PAS_C2CLS: begin
        first_charge_close_cmd  = 1'b1;
        bypass_open_cmd         = 1'b1;
        second_charge_close_cmd = 1'b1;
      end
      PAS_C1OPN, PAS_RSTW, PAS_DIAG, PAS_SYNC: begin
        bypass_open_cmd         = 1'b1;
        second_charge_close_cmd = 1'b1;
      end
      PAS_MAIN: begin
        bypass_open_cmd         = 1'b1;
        second_charge_close_cmd = 1'b1;
        main_input_close_cmd    = 1'b1;
      end
      PAS_C2OPN: begin
        bypass_open_cmd      = 1'b1;
        main_input_close_cmd = 1'b1;
      end
      PAS_DONE: begin
        // only a clean finish keeps the main path closed
        main_input_close_cmd = (cur_ff.exit_code == PAS_EX_SUCCESS);
        bypass_open_cmd      = (cur_ff.exit_code == PAS_EX_SUCCESS);
      end
      default: ;
    endcase
  end

  // bus answers at once, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = cur_ff.rdata;

  assign precharge_fault        = cur_ff.pfault;
  assign main_contactor_fault   = cur_ff.mfault;
  assign contactor_alarm        = cur_ff.calarm;
  assign breaker_opened_alarm   = cur_ff.balarm;
  assign contactor_still_closed = cur_ff.still;
  assign event_pulse            = cur_ff.event_p;
  assign irq = |(cur_ff.int_stat & cur_ff.int_mask);

endmodule : pas_supervisor

//--- logic/pas_params.svh
// offsets, field positions, reset values and timing for the precharge supervisor
`ifndef PAS_PARAMS_SVH
`define PAS_PARAMS_SVH

// register byte offsets
`define PAS_OFS_CTRL      8'h00
`define PAS_OFS_PRESCALE  8'h04
`define PAS_OFS_STATUS    8'h08
`define PAS_OFS_INT_STAT  8'h0C
`define PAS_OFS_INT_MASK  8'h10

// control register fields
`define PAS_CTRL_SERVICE  0

// status register fields
`define PAS_ST_EXIT_LSB   0
`define PAS_ST_STAGE_LSB  4
`define PAS_ST_BUSY       8
`define PAS_ST_STATE_LSB  12

// interrupt status and mask bit positions
`define PAS_IRQ_DONE      0
`define PAS_IRQ_PFAULT    1
`define PAS_IRQ_MFAULT    2
`define PAS_IRQ_CALARM    3
`define PAS_IRQ_BALARM    4
`define PAS_IRQ_BITS      5

// reset values
`define PAS_CTRL_RESET    1'b0
`define PAS_MASK_RESET    5'h00

// timing: clock rate, tick period and the two timeouts
`define PAS_CLK_MHZ       40
`define PAS_TICK_US       1000
`define PAS_TICK_CYCLES   (`PAS_TICK_US * `PAS_CLK_MHZ)
`define PAS_TICKS_PER_S   (1000000 / `PAS_TICK_US)
`define PAS_ACK_TIME_S    1
`define PAS_SEQ_TIME_S    30
`define PAS_ACK_TICKS     (`PAS_ACK_TIME_S * `PAS_TICKS_PER_S)
`define PAS_SEQ_TICKS     (`PAS_SEQ_TIME_S * `PAS_TICKS_PER_S)
`define PAS_TCNT_W        16

`endif

//--- logic/pas_pkg.sv
// types shared by the precharge supervisor modules
package pas_pkg;

  // sequencer states, one-hot
  typedef enum logic [11:0] {
    PAS_IDLE   = 12'h001,
    PAS_VOLTS  = 12'h002,
    PAS_C1CLS  = 12'h004,
    PAS_BYOPN  = 12'h008,
    PAS_C2CLS  = 12'h010,
    PAS_C1OPN  = 12'h020,
    PAS_RSTW   = 12'h040,
    PAS_DIAG   = 12'h080,
    PAS_SYNC   = 12'h100,
    PAS_MAIN   = 12'h200,
    PAS_C2OPN  = 12'h400,
    PAS_DONE   = 12'h800
  } pas_fsm_t;

  // exit status codes
  typedef enum logic [3:0] {
    PAS_EX_NONE        = 4'h0,
    PAS_EX_SUCCESS     = 4'h1,
    PAS_EX_TIMEOUT     = 4'h2,
    PAS_EX_C1_CLOSE    = 4'h3,
    PAS_EX_BYP_OPEN    = 4'h4,
    PAS_EX_C2_CLOSE    = 4'h5,
    PAS_EX_C1_OPEN     = 4'h6,
    PAS_EX_WAIT_RESET  = 4'h7,
    PAS_EX_MAIN_USER   = 4'h8,
    PAS_EX_ENA_LOST_MC = 4'h9,
    PAS_EX_LOW_DC_MC   = 4'hA,
    PAS_EX_NO_VOLT_MC  = 4'hB,
    PAS_EX_C2_OPEN     = 4'hC,
    PAS_EX_USER_ABORT  = 4'hD
  } pas_exit_t;

endpackage : pas_pkg

//--- logic/pas_time_if.sv
// timer requests and expiry flags between sequencer and timebase
`timescale 1ns/10ps
interface pas_time_if;
  logic short_restart;
  logic long_restart;
  logic long_run;
  logic short_expired;
  logic long_expired;

  modport ctrl  (output short_restart, output long_restart,
                 output long_run, input short_expired,
                 input long_expired);
  modport timer (input short_restart, input long_restart,
                 input long_run, output short_expired,
                 output long_expired);
endinterface : pas_time_if

//--- logic/pas_timebase.sv
// prescaled tick and the acknowledge and sequence timeout counters
`timescale 1ns/10ps
`include "pas_params.svh"
module pas_timebase
  import pas_pkg::*;
#(
  parameter int TCNT_W = `PAS_TCNT_W
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [31:0] tick_cycles,
  pas_time_if.timer        tm
);

  typedef struct packed {
    logic [31:0]     pre;
    logic [TCNT_W-1:0] ack_cnt;
    logic [TCNT_W-1:0] seq_cnt;
  } pas_tb_state_t;

  localparam logic [TCNT_W-1:0] ACK_TICKS = TCNT_W'(`PAS_ACK_TICKS);
  localparam logic [TCNT_W-1:0] SEQ_TICKS = TCNT_W'(`PAS_SEQ_TICKS);

  pas_tb_state_t cur_ff;
  pas_tb_state_t nxt_cur;
  logic          tick;

  // free running prescaler; a zero setting is treated as one cycle
  always_comb begin
    nxt_cur = cur_ff;
    tick    = (cur_ff.pre + 32'h1 >= tick_cycles);
    nxt_cur.pre = tick ? 32'h0 : cur_ff.pre + 32'h1;
    // ack timer restarts at each command, saturates when expired
    if (tm.short_restart) begin
      nxt_cur.ack_cnt = '0;
    end else if (tick && cur_ff.ack_cnt < ACK_TICKS) begin
      nxt_cur.ack_cnt = cur_ff.ack_cnt + TCNT_W'(1);
    end
    // sequence timer only runs from the voltage build-up wait through the first charge open stage
    if (tm.long_restart || !tm.long_run) begin
      nxt_cur.seq_cnt = '0;
    end else if (tick && cur_ff.seq_cnt < SEQ_TICKS) begin
      nxt_cur.seq_cnt = cur_ff.seq_cnt + TCNT_W'(1);
    end
  end

  assign tm.short_expired = (cur_ff.ack_cnt >= ACK_TICKS);
  assign tm.long_expired  = (cur_ff.seq_cnt >= SEQ_TICKS);

  // single state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule : pas_timebase

//--- verification/pas_supervisor_assertions.sv
// concurrent checks on the precharge supervisor ports
`timescale 1ns/10ps
module pas_supervisor_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic mv_built_up,
  input wire logic first_charge_closed_ack,
  input wire logic first_charge_close_cmd,
  input wire logic bypass_open_cmd,
  input wire logic main_input_close_cmd,
  input wire logic precharge_fault,
  input wire logic main_contactor_fault,
  input wire logic contactor_alarm,
  input wire logic breaker_opened_alarm,
  input wire logic contactor_still_closed,
  input wire logic event_pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // exit outcome appears together with its one-cycle pulse
  property p_pulse; event_pulse |=> !event_pulse; endproperty
  a_pulse: assert property (p_pulse)
    else $error("event pulse longer than one cycle");
  property p_pf; $rose(precharge_fault) |-> event_pulse; endproperty
  a_pf: assert property (p_pf)
    else $error("precharge fault without event pulse");
  property p_ca; $rose(contactor_alarm) |-> precharge_fault && event_pulse;
  endproperty
  a_ca: assert property (p_ca)
    else $error("contactor alarm without precharge fault");
  property p_ba; $rose(breaker_opened_alarm) |-> contactor_alarm; endproperty
  a_ba: assert property (p_ba)
    else $error("breaker alarm without contactor alarm");
  property p_sc; $rose(contactor_still_closed) |-> breaker_opened_alarm;
  endproperty
  a_sc: assert property (p_sc)
    else $error("still closed without breaker alarm");
  // main contactor faults only arise while waiting on main close
  property p_mf;
    $rose(main_contactor_fault) |->
      event_pulse && !precharge_fault && $past(main_input_close_cmd);
  endproperty
  a_mf: assert property (p_mf)
    else $error("main fault outside main close wait");
  // stages advance only on their condition from the previous edge
  property p_c1; $rose(first_charge_close_cmd) |-> $past(mv_built_up);
  endproperty
  a_c1: assert property (p_c1)
    else $error("first charge close before voltage built up");
  property p_by; $rose(bypass_open_cmd) |-> $past(first_charge_closed_ack);
  endproperty
  a_by: assert property (p_by)
    else $error("bypass opened before first charge ack");
endmodule : pas_supervisor_assertions

//--- verification/pas_contactor_model.sv
// contactor bank: each ack follows its command after a travel delay
`timescale 1ns/10ps
module pas_contactor_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [3:0] cmd,
  input  wire logic [3:0] refuse_close,
  input  wire logic [3:0] refuse_open,
  output logic      [3:0] ack
);
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;

  // a refused move leaves the ack where it was, as a welded contact would
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      ack   <= 4'h0;
    end else begin
      s1_ff <= cmd;
      s2_ff <= s1_ff;
      ack   <= (s2_ff & (ack | ~refuse_close))
             | (~s2_ff & ack & refuse_open);
    end
  end
endmodule : pas_contactor_model

//--- verification/tb.sv
// self-checking bench for the precharge supervisor
`timescale 1ns/10ps
module tb;
  logic        clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, en = 1'b0, dis = 1'b0, mvb = 1'b1;
  logic        lvl = 1'b1, ldc = 1'b0, diag = 1'b1, frd = 1'b1, syn = 1'b1;
  wire  [3:0]  cmd;
  logic [3:0]  ack, rcl = 4'h0, rop = 4'h0;
  logic        pf, mf, ca, ba, sc, ev, irq;
  int          num_errors = 0, n_checks = 0, cyc = 0;
  logic [3:0]  rc_t [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h0, 4'h0};
  logic [3:0]  ro_t [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h4};
  logic [3:0]  cd_t [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC};
  logic [4:0]  fl_t [6] = '{5'h00, 5'h14, 5'h16, 5'h14, 5'h16, 5'h17};

  always #12.5 clock = ~clock;

  // one-cycle tick keeps 1 s at 1000 cycles and 30 s at 30000
  pas_supervisor #(.TICK_CYCLES(32'h1)) pas_supervisor_i (
    .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .precharge_enable_flag(en), .main_input_disable_flag(dis),
    .mv_built_up(mvb), .medium_voltage_level_ok(lvl), .cell_low_dc_bus(ldc),
    .cell_diag_done(diag), .fault_reset_done(frd), .in_sync_relay(syn),
    .first_charge_closed_ack(ack[0]), .bypass_open_ack(ack[1]),
    .second_charge_closed_ack(ack[2]), .main_input_closed_ack(ack[3]),
    .first_charge_close_cmd(cmd[0]), .bypass_open_cmd(cmd[1]),
    .second_charge_close_cmd(cmd[2]), .main_input_close_cmd(cmd[3]),
    .precharge_fault(pf), .main_contactor_fault(mf), .contactor_alarm(ca),
    .breaker_opened_alarm(ba), .contactor_still_closed(sc),
    .event_pulse(ev), .irq);
  pas_contactor_model pas_contactor_model_i (.clock, .reset, .cmd,
    .refuse_close(rcl), .refuse_open(rop), .ack);

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : bus

  task automatic start;
    @(posedge clock);
    en <= 1'b1;
  endtask : start

  task automatic wait_main;
    while (cmd[3] !== 1'b1) @(posedge clock);
    @(posedge clock);
  endtask : wait_main

  // wait for the exit, check outcome, then withdraw enable
  task automatic finish(input logic [3:0] code, input logic [4:0] f);
    int i;
    i = 0;
    while (ev !== 1'b1 && i < 40000) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk("pulse", 32'h1, 32'(ev));
    chk("faults", 32'(f), 32'({pf, mf, ca, ba, sc}));
    bus(1'b0, 32'h08, 32'h0);
    chk("exit", 32'(code), 32'(rd[3:0]));
    en <= 1'b0;
    dis <= 1'b0;
    mvb <= 1'b1;
    lvl <= 1'b1;
    ldc <= 1'b0;
    diag <= 1'b1;
    frd <= 1'b1;
    rcl <= 4'h0;
    rop <= 4'h0;
    repeat (8) @(posedge clock);
  endtask : finish

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // hang guard; the tests need about 36000 cycles, mostly the 30 s wait
  always @(posedge clock) begin
    cyc++;
    if (cyc > 60000) begin
      num_errors++;
      final_report;
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, 32'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, 32'h04, 32'h0);
    chk("prescale", 32'h1, rd);
    for (int k = 0; k < 6; k++) begin
      rcl <= rc_t[k];
      rop <= ro_t[k];
      start;
      finish(cd_t[k], fl_t[k]);
    end
    mvb <= 1'b0;
    start;
    finish(4'h2, 5'h10);
    chk("stage", 32'h1, 32'(rd[7:4]));
    mvb <= 1'b0;
    dis <= 1'b1;
    start;
    finish(4'h8, 5'h10);
    frd <= 1'b0;
    start;
    repeat (60) @(posedge clock);
    mvb <= 1'b0;
    finish(4'h7, 5'h10);
    diag <= 1'b0;
    start;
    repeat (60) @(posedge clock);
    bus(1'b0, 32'h08, 32'h0);
    chk("busy", 32'h1, 32'(rd[8]));
    chk("state", 32'h080, 32'(rd[23:12]));
    ldc <= 1'b1;
    finish(4'h8, 5'h10);
    // enable dropped while voltage builds: plain user abort
    mvb <= 1'b0;
    start;
    repeat (20) @(posedge clock);
    en <= 1'b0;
    finish(4'hD, 5'h10);
    // main close wait: each abort cause in turn
    for (int m = 0; m < 4; m++) begin
      rcl <= 4'h8;
      start;
      wait_main;
      case (m)
        0: en <= 1'b0;
        1: dis <= 1'b1;
        2: ldc <= 1'b1;
        default: lvl <= 1'b0;
      endcase
      finish(m == 0 ? 4'h9 : m == 1 ? 4'h8 : m == 2 ? 4'hA : 4'hB,
             m < 2 ? 5'h10 : 5'h08);
    end
    bus(1'b1, 32'h00, 32'h1);
    start;
    finish(4'h1, 5'h00);
    bus(1'b1, 32'h00, 32'h0);
    // interrupt: masked, unmasked, then cleared by writing ones
    chk("irq_masked", 32'h0, 32'(irq));
    bus(1'b1, 32'h10, 32'h1F);
    repeat (2) @(posedge clock);
    #1;
    chk("irq_on", 32'h1, 32'(irq));
    bus(1'b1, 32'h0C, 32'h1F);
    repeat (2) @(posedge clock);
    #1;
    chk("irq_off", 32'h0, 32'(irq));
    bus(1'b0, 32'h0C, 32'h0);
    chk("int_stat", 32'h0, rd);
    final_report;
  end
endmodule : tb

bind pas_supervisor pas_supervisor_assertions pas_supervisor_assertions_i (
  .clock, .reset, .mv_built_up, .first_charge_closed_ack,
  .first_charge_close_cmd, .bypass_open_cmd, .main_input_close_cmd,
  .precharge_fault, .main_contactor_fault, .contactor_alarm,
  .breaker_opened_alarm, .contactor_still_closed, .event_pulse);
